/* shared/acd_params.svh */
/* Constants of the task-file command decoder: register indices, field
   positions, opcodes, reset values and timing counts.
   Included by bare name from the design modules and the bench. */
`ifndef ACD_PARAMS_SVH
`define ACD_PARAMS_SVH

// Register indices, byte address is four times the index
`define ACD_IDX_FEATURE  4'h1
`define ACD_IDX_SCOUNT   4'h2
`define ACD_IDX_SNUM     4'h3
`define ACD_IDX_CYL_LO   4'h4
`define ACD_IDX_CYL_HI   4'h5
`define ACD_IDX_DHEAD    4'h6
`define ACD_IDX_OPCODE   4'h7
`define ACD_IDX_STATUS   4'h8
`define ACD_IDX_IRQ_STAT 4'h9
`define ACD_IDX_IRQ_MASK 4'hA
`define ACD_IDX_IDENT    4'hB
`define ACD_IDX_UDMA_SEL 4'hC
`define ACD_IDX_LBA      4'hD
`define ACD_IDX_GEOM     4'hE
`define ACD_IDX_DATA     4'hF

// Field positions
`define ACD_DH_LBA       6
`define ACD_DH_DRIVE     4
`define ACD_ST_BUSY      0
`define ACD_ST_DRQ       1
`define ACD_ST_ERR       2
`define ACD_ST_ABRT      3
`define ACD_ST_APD       4
`define ACD_ST_STANDBY   5
`define ACD_ST_IDLE      6
`define ACD_IRQ_DONE     0
`define ACD_IRQ_ABRT     1
`define ACD_IRQ_PDOWN    2

// Opcodes
`define ACD_OP_NOP       8'h00
`define ACD_OP_IDLE_A    8'h97
`define ACD_OP_IDLE_B    8'hE3
`define ACD_OP_IDLI_A    8'h95
`define ACD_OP_IDLI_B    8'hE1
`define ACD_OP_GEOM      8'h91
`define ACD_OP_RBUF      8'hE4
`define ACD_OP_RDMA      8'hC8
`define ACD_OP_RMULT     8'hC4
`define ACD_OP_RLONG_A   8'h22
`define ACD_OP_RLONG_B   8'h23

// Reset values and defaults
`define ACD_RST_SPT      8'h20
`define ACD_RST_HEADS    5'h10
`define ACD_RST_UDMA_SEL 3'h0
`define ACD_UDMA_RSVD    3'h7
`define ACD_DEF_IO_MODE  3'h2
`define ACD_DEF_MEM_MODE 3'h2
`define ACD_DEF_UDMA_IO  3'h6
`define ACD_DEF_UDMA_MEM 3'h6
`define ACD_DEF_VALID    1'b1
`define ACD_SECTOR_WORDS 256

// Timing
`define ACD_CLK_HZ       50000000
`define ACD_APD_UNIT_MS  5
`define ACD_APD_UNIT_CYC (`ACD_CLK_HZ / 1000 * `ACD_APD_UNIT_MS)
`endif

/* shared/acd_pkg.sv */
/* Types of the task-file command decoder: controller states, power
   states and decoded command classes.
   Assumes nothing of its surroundings. */
`default_nettype none
package acd_pkg;
  typedef enum logic [1:0] {
    ST_IDLE  = 2'b00,
    ST_EXEC  = 2'b01,
    ST_MEDIA = 2'b11,
    ST_XFER  = 2'b10
  } acd_state_t;
  typedef enum logic [1:0] {
    PWR_ACTIVE  = 2'b00,
    PWR_IDLE    = 2'b01,
    PWR_STANDBY = 2'b10
  } acd_pwr_t;
  typedef enum logic [2:0] {
    CMD_ABORT, CMD_IDLE_T, CMD_IDLE_I, CMD_GEOM,
    CMD_RBUF, CMD_DMA, CMD_MULT, CMD_LONG
  } acd_cmd_t;
endpackage : acd_pkg
`default_nettype wire

/* hdl/acd_apd_timer.sv */
/* Automatic power-down timer: counts whole time units down from a
   loaded value and pulses once on expiry.
   Assumes load is a one-cycle pulse on the same clock. */
`timescale 1ns/10ps
`default_nettype none
`include "acd_params.svh"
module acd_apd_timer #(
  parameter int UNIT_CYC = `ACD_APD_UNIT_CYC
) (
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       reset,
  // Control
  input  wire logic       load,
  input  wire logic [7:0] count,
  // Status
  output logic            armed,
  output logic            expire
);
  // One bit of headroom keeps UNIT_CYC of 1 legal
  localparam int PW = $clog2(UNIT_CYC + 1);
  logic [PW-1:0] pre_reg;
  logic [7:0]    left_reg;
  wire           tick = armed && (pre_reg == PW'(UNIT_CYC - 1));
  wire           last = tick && (left_reg == 8'h01);

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      pre_reg  <= '0;
      left_reg <= 8'h00;
      armed    <= 1'b0;
      expire   <= 1'b0;
    end else if (load) begin
      pre_reg  <= '0;
      left_reg <= count;
      armed    <= (count != 8'h00);
      expire   <= 1'b0;
    end else begin
      pre_reg  <= tick ? '0 : pre_reg + PW'(armed);
      left_reg <= tick ? left_reg - 8'h01 : left_reg;
      armed    <= armed && !last;
      expire   <= last;
    end
  end
endmodule : acd_apd_timer
`default_nettype wire

/* hdl/acd_sector_buf.sv */
/* Sector buffer: filled word by word from the media side, drained word
   by word by the host data port; both pointers wrap per sector.
   Assumes fill and drain are never asked for the same sector at once. */
`timescale 1ns/10ps
`default_nettype none
`include "acd_params.svh"
module acd_sector_buf #(
  parameter int WORDS = `ACD_SECTOR_WORDS,
  parameter int DW    = 16
) (
  // Clock and reset
  input  wire logic          clk,
  input  wire logic          reset,
  // Fill side
  input  wire logic          fill_rst,
  input  wire logic          fill_en,
  input  wire logic [DW-1:0] fill_data,
  // Drain side
  input  wire logic          drain_rst,
  input  wire logic          drain_en,
  output logic      [DW-1:0] drain_data,
  output logic               drain_last
);
  localparam int AW = $clog2(WORDS);
  logic [DW-1:0] mem [WORDS];
  logic [AW-1:0] fill_ptr;
  logic [AW-1:0] drain_ptr;
  wire           fill_end = fill_ptr == AW'(WORDS - 1);

  assign drain_data = mem[drain_ptr];
  assign drain_last = drain_ptr == AW'(WORDS - 1);

  always_ff @(posedge clk) begin
    if (fill_en) mem[fill_ptr] <= fill_data;
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      fill_ptr  <= '0;
      drain_ptr <= '0;
    end else begin
      if (fill_rst) fill_ptr <= '0;
      else if (fill_en) fill_ptr <= fill_end ? '0 : fill_ptr + AW'(1);
      if (drain_rst) drain_ptr <= '0;
      else if (drain_en) drain_ptr <= drain_last ? '0 : drain_ptr + AW'(1);
    end
  end
endmodule : acd_sector_buf
`default_nettype wire

/* hdl/acd_top.sv */
/* Task-file command decoder: task-file registers, command execution,
   identify word 164, power-down timer and interrupt, all behind an
   Avalon-MM slave with waitrequest.
   Assumes one clock; media back end and buffer filler share it. */
// Added by the designer: the Avalon-MM slave port.
`timescale 1ns/10ps
`default_nettype none
`include "acd_params.svh"
module acd_top #(
  parameter logic       DRIVE_ID     = 1'b0,
  parameter int         APD_UNIT_CYC = `ACD_APD_UNIT_CYC,
  parameter int         SECTOR_WORDS = `ACD_SECTOR_WORDS,
  parameter logic [2:0] IO_MODE      = `ACD_DEF_IO_MODE,
  parameter logic [2:0] MEM_MODE     = `ACD_DEF_MEM_MODE,
  parameter logic [2:0] UDMA_IO_MAX  = `ACD_DEF_UDMA_IO,
  parameter logic [2:0] UDMA_MEM_MAX = `ACD_DEF_UDMA_MEM,
  parameter logic       UDMA_VALID   = `ACD_DEF_VALID
) (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        reset,
  // Avalon-MM register slave
  input  wire logic [5:0]  avs_address,
  input  wire logic [3:0]  avs_byteenable,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  output logic      [31:0] avs_readdata,
  output logic             avs_waitrequest,
  output logic             irq,
  // Media back end
  output logic             media_req,
  output logic      [27:0] media_lba,
  output logic      [8:0]  media_count,
  output logic             media_dma,
  output logic             media_long,
  input  wire logic        media_done,
  // Sector buffer fill
  input  wire logic        fill_en,
  input  wire logic [15:0] fill_data
);
  acd_pkg::acd_state_t st_reg;
  acd_pkg::acd_state_t st_next;
  acd_pkg::acd_pwr_t   pwr_reg;
  acd_pkg::acd_cmd_t   cmd_w;
  logic [7:0]  scnt_reg;
  logic [7:0]  snum_reg;
  logic [7:0]  cyl_lo_reg;
  logic [7:0]  cyl_hi_reg;
  logic [7:0]  dh_reg;
  logic [7:0]  op_reg;
  logic [7:0]  spt_reg;
  logic [4:0]  heads_reg;
  logic [2:0]  udma_sel_reg;
  logic [2:0]  irq_stat_reg;
  logic [2:0]  irq_stat_next;
  logic [2:0]  irq_mask_reg;
  logic        err_reg;
  logic        abrt_reg;
  logic [8:0]  left_reg;
  logic [31:0] rd_mux;
  logic [7:0]  stat_w;
  logic [15:0] drain_data;
  logic        drain_last;
  logic        apd_armed;
  logic        apd_expire;

  function automatic acd_pkg::acd_cmd_t op_decode(input logic [7:0] op);
    if (op == `ACD_OP_IDLE_A || op == `ACD_OP_IDLE_B)
      return acd_pkg::CMD_IDLE_T;
    if (op == `ACD_OP_IDLI_A || op == `ACD_OP_IDLI_B)
      return acd_pkg::CMD_IDLE_I;
    if (op == `ACD_OP_GEOM) return acd_pkg::CMD_GEOM;
    if (op == `ACD_OP_RBUF) return acd_pkg::CMD_RBUF;
    if (op == `ACD_OP_RDMA) return acd_pkg::CMD_DMA;
    if (op == `ACD_OP_RMULT) return acd_pkg::CMD_MULT;
    if (op == `ACD_OP_RLONG_A || op == `ACD_OP_RLONG_B)
      return acd_pkg::CMD_LONG;
    // Opcode 00h and anything unknown end aborted
    return acd_pkg::CMD_ABORT;
  endfunction : op_decode

  // Task file to block address; CHS goes through the set geometry
  function automatic logic [27:0] tf_lba(
    input logic [7:0] dh, input logic [7:0] ch, input logic [7:0] cl,
    input logic [7:0] sn, input logic [7:0] sp, input logic [4:0] hd);
    logic [28:0] chs;
    chs = 29'({ch, cl}) * 29'(hd) + 29'(dh[3:0]);
    chs = chs * 29'(sp) + 29'(sn) - 29'h1;
    if (dh[`ACD_DH_LBA]) return {dh[3:0], ch, cl, sn};
    return chs[27:0];
  endfunction : tf_lba

  // Bus decode
  wire [3:0]  idx    = avs_address[5:2];
  wire [7:0]  wd     = avs_writedata[7:0];
  wire        req    = avs_read || avs_write;
  wire        acc    = req && !avs_waitrequest;
  wire        acc_rd = acc && avs_read;
  wire        acc_wr = acc && avs_write && avs_byteenable[0]
                       && (avs_address[1:0] == 2'b00);
  wire        busy   = st_reg != acd_pkg::ST_IDLE;
  // Task file is frozen while a command runs
  wire        tf_wr  = acc_wr && !busy;
  wire        wr_op  = tf_wr && (idx == `ACD_IDX_OPCODE);
  wire        take   = wr_op && (dh_reg[`ACD_DH_DRIVE] == DRIVE_ID);
  wire        exec   = st_reg == acd_pkg::ST_EXEC;
  wire        xfer   = st_reg == acd_pkg::ST_XFER;
  wire        rd_dat = acc_rd && (idx == `ACD_IDX_DATA) && xfer;
  wire        s_end  = rd_dat && drain_last;
  wire        finish = busy && (st_next == acd_pkg::ST_IDLE);
  wire [27:0] lba_w  = tf_lba(dh_reg, cyl_hi_reg, cyl_lo_reg, snum_reg,
                              spt_reg, heads_reg);
  // Zero sector count means 256 sectors
  wire [8:0]  len_w  = (scnt_reg == 8'h00) ? 9'h100 : {1'b0, scnt_reg};
  wire        is_med = cmd_w == acd_pkg::CMD_DMA
                       || cmd_w == acd_pkg::CMD_MULT
                       || cmd_w == acd_pkg::CMD_LONG;
  wire        is_idl = cmd_w == acd_pkg::CMD_IDLE_T
                       || cmd_w == acd_pkg::CMD_IDLE_I;
  wire        is_abt = cmd_w == acd_pkg::CMD_ABORT;
  wire        ld_apd = exec && (cmd_w == acd_pkg::CMD_IDLE_T);
  wire [2:0]  w1c    = (acc_wr && idx == `ACD_IDX_IRQ_STAT) ? wd[2:0] : 3'h0;
  wire [2:0]  ev_set = {apd_expire, exec && is_abt, finish};
  // Fields 11-6 read zero when the UDMA report is marked invalid
  wire [5:0]  udma_w = UDMA_VALID ? {UDMA_MEM_MAX, UDMA_IO_MAX} : 6'h00;
  wire [15:0] ident_w = {UDMA_VALID, udma_sel_reg, udma_w,
                         MEM_MODE, IO_MODE};

  assign cmd_w = op_decode(op_reg);
  // Set wins over a write-one-to-clear in the same cycle
  assign irq_stat_next = (irq_stat_reg & ~w1c) | ev_set;

  always_comb begin
    stat_w = 8'h00;
    stat_w[`ACD_ST_BUSY]    = busy;
    stat_w[`ACD_ST_DRQ]     = xfer;
    stat_w[`ACD_ST_ERR]     = err_reg;
    stat_w[`ACD_ST_ABRT]    = abrt_reg;
    stat_w[`ACD_ST_APD]     = apd_armed;
    stat_w[`ACD_ST_STANDBY] = pwr_reg == acd_pkg::PWR_STANDBY;
    stat_w[`ACD_ST_IDLE]    = pwr_reg == acd_pkg::PWR_IDLE;
  end

  always_comb begin
    rd_mux = 32'h0000_0000;
    if (idx == `ACD_IDX_SCOUNT) rd_mux = {24'h0, scnt_reg};
    else if (idx == `ACD_IDX_SNUM) rd_mux = {24'h0, snum_reg};
    else if (idx == `ACD_IDX_CYL_LO) rd_mux = {24'h0, cyl_lo_reg};
    else if (idx == `ACD_IDX_CYL_HI) rd_mux = {24'h0, cyl_hi_reg};
    else if (idx == `ACD_IDX_DHEAD) rd_mux = {24'h0, dh_reg};
    else if (idx == `ACD_IDX_STATUS) rd_mux = {24'h0, stat_w};
    else if (idx == `ACD_IDX_IRQ_STAT) rd_mux = {29'h0, irq_stat_reg};
    else if (idx == `ACD_IDX_IRQ_MASK) rd_mux = {29'h0, irq_mask_reg};
    else if (idx == `ACD_IDX_IDENT) rd_mux = {16'h0, ident_w};
    else if (idx == `ACD_IDX_UDMA_SEL) rd_mux = {29'h0, udma_sel_reg};
    else if (idx == `ACD_IDX_LBA) rd_mux = {4'h0, lba_w};
    else if (idx == `ACD_IDX_GEOM) rd_mux = {19'h0, heads_reg, spt_reg};
    else if (idx == `ACD_IDX_DATA) rd_mux = {16'h0, drain_data};
  end

  always_comb begin
    st_next = st_reg;
    case (st_reg)
      acd_pkg::ST_IDLE: begin
        if (take) st_next = acd_pkg::ST_EXEC;
      end
      acd_pkg::ST_EXEC: begin
        if (cmd_w == acd_pkg::CMD_RBUF) st_next = acd_pkg::ST_XFER;
        else if (is_med) st_next = acd_pkg::ST_MEDIA;
        else st_next = acd_pkg::ST_IDLE;
      end
      acd_pkg::ST_MEDIA: begin
        // DMA data bypasses the buffer; done ends the whole command
        if (media_done)
          st_next = media_dma ? acd_pkg::ST_IDLE : acd_pkg::ST_XFER;
      end
      acd_pkg::ST_XFER: begin
        if (s_end)
          st_next = (left_reg == 9'h001) ? acd_pkg::ST_IDLE
                                         : acd_pkg::ST_MEDIA;
      end
      default: st_next = acd_pkg::ST_IDLE;
    endcase
  end

  // Bus handshake: one wait cycle, read data captured before accept
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      avs_waitrequest <= 1'b1;
      avs_readdata    <= 32'h0000_0000;
    end else begin
      avs_waitrequest <= !(req && avs_waitrequest);
      if (req && avs_waitrequest) avs_readdata <= rd_mux;
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      scnt_reg   <= 8'h00;
      snum_reg   <= 8'h00;
      cyl_lo_reg <= 8'h00;
      cyl_hi_reg <= 8'h00;
      dh_reg     <= 8'h00;
    end else if (tf_wr) begin
      if (idx == `ACD_IDX_SCOUNT) scnt_reg <= wd;
      if (idx == `ACD_IDX_SNUM) snum_reg <= wd;
      if (idx == `ACD_IDX_CYL_LO) cyl_lo_reg <= wd;
      if (idx == `ACD_IDX_CYL_HI) cyl_hi_reg <= wd;
      if (idx == `ACD_IDX_DHEAD) dh_reg <= wd;
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      irq_stat_reg <= 3'h0;
      irq_mask_reg <= 3'h0;
      udma_sel_reg <= `ACD_RST_UDMA_SEL;
      irq          <= 1'b0;
    end else begin
      irq_stat_reg <= irq_stat_next;
      irq          <= |(irq_stat_reg & irq_mask_reg);
      if (acc_wr && idx == `ACD_IDX_IRQ_MASK) irq_mask_reg <= wd[2:0];
      if (acc_wr && idx == `ACD_IDX_UDMA_SEL && wd[2:0] != `ACD_UDMA_RSVD)
        udma_sel_reg <= wd[2:0];
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      st_reg   <= acd_pkg::ST_IDLE;
      op_reg   <= `ACD_OP_NOP;
      err_reg  <= 1'b0;
      abrt_reg <= 1'b0;
      left_reg <= 9'h000;
    end else begin
      st_reg <= st_next;
      if (take) op_reg <= wd;
      if (take) err_reg <= 1'b0;
      else if (exec && is_abt) err_reg <= 1'b1;
      if (take) abrt_reg <= 1'b0;
      else if (exec && is_abt) abrt_reg <= 1'b1;
      if (exec)
        left_reg <= (is_med && cmd_w != acd_pkg::CMD_LONG) ? len_w
                                                            : 9'h001;
      else if (s_end) left_reg <= left_reg - 9'h001;
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      pwr_reg   <= acd_pkg::PWR_ACTIVE;
      spt_reg   <= `ACD_RST_SPT;
      heads_reg <= `ACD_RST_HEADS;
    end else begin
      if (exec && is_idl) pwr_reg <= acd_pkg::PWR_IDLE;
      else if (exec && is_med) pwr_reg <= acd_pkg::PWR_ACTIVE;
      else if (apd_expire && !busy) pwr_reg <= acd_pkg::PWR_STANDBY;
      if (exec && cmd_w == acd_pkg::CMD_GEOM) begin
        spt_reg   <= scnt_reg;
        heads_reg <= 5'(dh_reg[3:0]) + 5'h01;
      end
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      media_req   <= 1'b0;
      media_lba   <= 28'h0000000;
      media_count <= 9'h000;
      media_dma   <= 1'b0;
      media_long  <= 1'b0;
    end else begin
      media_req <= exec && is_med;
      if (exec && is_med) begin
        media_lba   <= lba_w;
        media_count <= (cmd_w == acd_pkg::CMD_LONG) ? 9'h001 : len_w;
        media_dma   <= cmd_w == acd_pkg::CMD_DMA;
        media_long  <= cmd_w == acd_pkg::CMD_LONG;
      end
    end
  end

  acd_apd_timer #(
    .UNIT_CYC (APD_UNIT_CYC)
  ) u_apd (
    .clk    (clk),
    .reset  (reset),
    .load   (ld_apd),
    .count  (scnt_reg),
    .armed  (apd_armed),
    .expire (apd_expire)
  );

  acd_sector_buf #(
    .WORDS (SECTOR_WORDS),
    .DW    (16)
  ) u_buf (
    .clk        (clk),
    .reset      (reset),
    .fill_rst   (exec && is_med),
    .fill_en    (fill_en),
    .fill_data  (fill_data),
    .drain_rst  (exec),
    .drain_en   (rd_dat),
    .drain_data (drain_data),
    .drain_last (drain_last)
  );

  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  wire take_idl = take && op_decode(wd) == acd_pkg::CMD_IDLE_T;

  sequence s_exec_then_done;
    (st_reg == acd_pkg::ST_EXEC) ##1
    (st_reg == acd_pkg::ST_IDLE && irq_stat_reg[`ACD_IRQ_DONE]
     && pwr_reg == acd_pkg::PWR_IDLE);
  endsequence

  a_ident_io_mode: assert property (
    acc_rd && idx == `ACD_IDX_IDENT |-> avs_readdata[2:0] == IO_MODE)
    else $error("identify I/O mode field wrong");
  a_ident_mem_mode: assert property (
    acc_rd && idx == `ACD_IDX_IDENT |-> avs_readdata[5:3] == MEM_MODE)
    else $error("identify memory mode field wrong");
  a_ident_udma_max: assert property (
    acc_rd && idx == `ACD_IDX_IDENT |-> avs_readdata[15] == UDMA_VALID
    && avs_readdata[11:6] == udma_w)
    else $error("identify UDMA fields wrong");
  a_udma_sel_upd: assert property (
    acc_wr && idx == `ACD_IDX_UDMA_SEL && wd[2:0] != `ACD_UDMA_RSVD
    |=> ident_w[14:12] == $past(wd[2:0]))
    else $error("selected UDMA mode not reported");
  a_idle_done: assert property (
    take_idl |=> s_exec_then_done)
    else $error("idle command sequence wrong");
  a_apd_armed: assert property (
    take_idl && scnt_reg != 8'h00 |-> ##2 apd_armed)
    else $error("power-down timer not armed");
  a_apd_off: assert property (
    take_idl && scnt_reg == 8'h00 |-> ##2 !apd_armed)
    else $error("power-down timer not disabled");
  a_idli_keep: assert property (
    take && op_decode(wd) == acd_pkg::CMD_IDLE_I |=> s_exec_then_done
    ##0 (apd_armed == $past(apd_armed, 2) || apd_expire || $past(apd_expire)))
    else $error("idle immediate disturbed the timer");
  a_geom_set: assert property (
    take && wd == `ACD_OP_GEOM |-> ##2 spt_reg == $past(scnt_reg, 2)
    && heads_reg == 5'($past(dh_reg[3:0], 2)) + 5'h01)
    else $error("geometry not taken");
  a_nop_abort: assert property (
    take && wd == `ACD_OP_NOP |-> ##2 err_reg && abrt_reg
    && irq_stat_reg[`ACD_IRQ_ABRT] && st_reg == acd_pkg::ST_IDLE)
    else $error("opcode 00h not aborted");
  a_rbuf_drq: assert property (
    take && wd == `ACD_OP_RBUF |-> ##2 xfer && !media_req)
    else $error("read buffer did not enter data phase");
  a_dma_addr: assert property (
    take && wd == `ACD_OP_RDMA |-> ##2 media_req && media_dma
    && media_lba == $past(lba_w, 2) && media_count == $past(len_w, 2))
    else $error("read DMA address or length wrong");
  a_long_one: assert property (
    take && op_decode(wd) == acd_pkg::CMD_LONG |-> ##2 media_req
    && media_long && media_count == 9'h001)
    else $error("read long not one sector");
  a_drive_sel: assert property (
    wr_op && dh_reg[`ACD_DH_DRIVE] != DRIVE_ID |=> st_reg == acd_pkg::ST_IDLE)
    else $error("other drive's command executed");
endmodule : acd_top
`default_nettype wire

/* dv/acd_media_model.sv */
/* Media back end model: answers each PIO media request with one sector of
   patterned words into the buffer, then a done pulse.
   Assumes one PIO sector per request and the bench's clock. */
`timescale 1ns/10ps
`default_nettype none
module acd_media_model #(
  parameter int WORDS = 8,
  parameter int DLY   = 3
) (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        reset,
  // Request side
  input  wire logic        media_req,
  input  wire logic        media_dma,
  // Answer side
  output logic             media_done,
  output logic             fill_en,
  output logic      [15:0] fill_data
);
  initial begin
    media_done = 1'b0;
    fill_en = 1'b0;
    fill_data = 16'h0000;
    forever begin
      @(posedge clk);
      if (media_req === 1'b1 && !reset) begin
        repeat (DLY) @(posedge clk);
        // DMA data bypasses the buffer, so no words
        for (int i = 0; i < WORDS && !media_dma; i++) begin
          fill_en <= 1'b1;
          fill_data <= 16'hA500 + 16'(i);
          @(posedge clk);
        end
        fill_en <= 1'b0;
        fill_data <= ~fill_data;
        media_done <= 1'b1;
        @(posedge clk);
        media_done <= 1'b0;
      end
    end
  end
endmodule : acd_media_model
`default_nettype wire

/* dv/acd_top_tb_top.sv */
/* Self-checking bench of the command decoder: register bus tasks,
   table of address cases, then idle, abort, geometry and read cases.
   Assumes the media model answers every media request. */
`timescale 1ns/10ps
`default_nettype none
`include "acd_params.svh"
module acd_top_tb_top;
  localparam int SW = 8;
  localparam logic [31:0] IDW = {16'h0000, `ACD_DEF_VALID, 3'h0,
    `ACD_DEF_UDMA_MEM, `ACD_DEF_UDMA_IO, `ACD_DEF_MEM_MODE, `ACD_DEF_IO_MODE};
  typedef struct packed {logic [7:0] dh, ch, cl, sn;
                         logic [27:0] lba;} acd_row_t;
  acd_row_t rows [4] = '{'{8'h4F, 8'hAB, 8'hCD, 8'hEF, 28'hFABCDEF},
    '{8'h40, 8'h00, 8'h00, 8'h01, 28'h0000001},
    '{8'h00, 8'h00, 8'h00, 8'h01, 28'h0000000},
    '{8'h01, 8'h00, 8'h01, 8'h02, 28'h0000221}};
  logic [7:0] ops [4] = '{8'h97, 8'hE1, 8'hE3, 8'h95};
  logic [7:0] cnts [4] = '{8'h03, 8'h00, 8'h00, 8'h09};
  logic        clk, reset, avs_read, avs_write, avs_waitrequest, irq;
  logic        media_req, media_dma, media_long, media_done, fill_en;
  logic [5:0]  avs_address;
  logic [31:0] avs_writedata, avs_readdata, q;
  logic [27:0] media_lba;
  logic [8:0]  media_count;
  logic [15:0] fill_data;
  int          mismatches, check_count;

  acd_top #(.APD_UNIT_CYC(20), .SECTOR_WORDS(SW)) i_dut (.clk(clk),
    .reset(reset), .avs_address(avs_address), .avs_byteenable(4'hF),
    .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .irq(irq), .media_req(media_req),
    .media_lba(media_lba), .media_count(media_count), .media_dma(media_dma),
    .media_long(media_long), .media_done(media_done), .fill_en(fill_en),
    .fill_data(fill_data));
  acd_media_model #(.WORDS(SW)) i_media (.clk(clk), .reset(reset),
    .media_req(media_req), .media_dma(media_dma), .media_done(media_done),
    .fill_en(fill_en), .fill_data(fill_data));

  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  task automatic stop_test();
    $display("Checks %0d, mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : stop_test

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      mismatches++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // Request held until waitrequest is seen low at an edge
  task automatic bus(input logic w, input logic [3:0] idx,
                     input logic [31:0] d);
    int n;
    n = 0;
    avs_address <= {idx, 2'b00};
    avs_writedata <= d;
    avs_write <= w;
    avs_read <= !w;
    do begin
      @(posedge clk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 20);
    q = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    if (n == 20) begin
      mismatches++;
      stop_test();
    end
    @(posedge clk);
  endtask : bus

  task automatic rchk(input logic [3:0] idx, input logic [31:0] m,
                      input logic [31:0] exp);
    bus(1'b0, idx, 32'h0);
    chk(q & m, exp);
  endtask : rchk

  // Polls status until the chosen bit reaches the wanted level
  task automatic wait_st(input int b, input logic v);
    int n;
    n = 0;
    do begin
      bus(1'b0, 4'h8, 32'h0);
      n++;
    end while (q[b] !== v && n < 60);
    if (n == 60) begin
      mismatches++;
      stop_test();
    end
  endtask : wait_st

  task automatic cmd(input logic [7:0] op);
    bus(1'b1, 4'h7, {24'h0, op});
    wait_st(`ACD_ST_BUSY, 1'b0);
  endtask : cmd

  task automatic words();
    wait_st(`ACD_ST_DRQ, 1'b1);
    for (int i = 0; i < SW; i++) rchk(4'hF, 32'hFFFF, 32'hA500 + i);
  endtask : words

  initial begin
    mismatches = 0;
    check_count = 0;
    reset = 1'b1;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_address = 6'h00;
    avs_writedata = 32'h0;
    repeat (10) @(posedge clk);
    reset <= 1'b0;
    @(posedge clk);
    rchk(4'hE, 32'hFFFF, 32'h1020);
    rchk(4'hB, 32'hFFFF, IDW);
    bus(1'b1, 4'hC, 32'h5);
    bus(1'b1, 4'hC, 32'h7);
    rchk(4'hB, 32'hFFFF, IDW | 32'h5000);
    foreach (rows[i]) begin
      bus(1'b1, 4'h6, rows[i].dh);
      bus(1'b1, 4'h5, rows[i].ch);
      bus(1'b1, 4'h4, rows[i].cl);
      bus(1'b1, 4'h3, rows[i].sn);
      rchk(4'hD, 32'hFFFFFFF, rows[i].lba);
    end
    bus(1'b1, 4'hA, 32'h7);
    bus(1'b1, 4'h6, 32'h00);
    foreach (ops[i]) begin
      bus(1'b1, 4'h2, cnts[i]);
      cmd(ops[i]);
      chk(q & 32'h51, {25'h0, 1'b1, 1'b0, i < 2, 4'h0});
      rchk(4'h9, 32'h3, 32'h1);
      chk(irq, 1'b1);
      bus(1'b1, 4'h9, 32'h7);
      rchk(4'h9, 32'h7, 32'h0);
      chk(irq, 1'b0);
    end
    bus(1'b1, 4'h2, 32'h2);
    cmd(8'h97);
    rchk(4'h9, 32'h4, 32'h0);
    wait_st(`ACD_ST_STANDBY, 1'b1);
    rchk(4'h9, 32'h4, 32'h4);
    cmd(8'h00);
    chk(q & 32'h0C, 32'h0C);
    rchk(4'h9, 32'h2, 32'h2);
    bus(1'b1, 4'h9, 32'h7);
    bus(1'b1, 4'h6, 32'h10);
    bus(1'b1, 4'h7, 32'hE1);
    rchk(4'h9, 32'h7, 32'h0);
    // Heads minus one in the low nibble, addressing bit clear
    bus(1'b1, 4'h2, 32'h10);
    bus(1'b1, 4'h6, 32'h03);
    cmd(8'h91);
    rchk(4'hE, 32'h1FFF, 32'h0410);
    bus(1'b1, 4'h6, 32'h4A);
    bus(1'b1, 4'h5, 32'h12);
    bus(1'b1, 4'h4, 32'h34);
    bus(1'b1, 4'h3, 32'h56);
    bus(1'b1, 4'h2, 32'h00);
    cmd(8'hC8);
    chk({media_dma, media_count}, {1'b1, 9'h100});
    chk(media_lba, 28'hA123456);
    bus(1'b1, 4'h2, 32'h05);
    bus(1'b1, 4'h7, 32'h23);
    words();
    wait_st(`ACD_ST_BUSY, 1'b0);
    chk({media_long, media_count}, {1'b1, 9'h001});
    bus(1'b1, 4'h3, 32'h78);
    bus(1'b1, 4'h2, 32'h01);
    bus(1'b1, 4'h7, 32'hC4);
    words();
    wait_st(`ACD_ST_BUSY, 1'b0);
    chk({media_dma, media_long, media_count}, {2'b00, 9'h001});
    chk(media_lba, 28'hA123478);
    bus(1'b1, 4'h7, 32'hE4);
    words();
    stop_test();
  end
endmodule : acd_top_tb_top
`default_nettype wire
